// [core/dcr_pkg.sv]
/*
  Constants and types for the DAC code register port: register pointer map,
  two-wire address values, reset codes and the state record of the port.
  Assumes a single system clock; every other file imports this package.
*/
package dcr_pkg;

  // register file geometry
  localparam int NUM_REGS = 20;
  localparam int CODE_W = 10;
  localparam int PTR_W = 5;

  // register pointers
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_01_PTR = 5'h00;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_02_PTR = 5'h01;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_03_PTR = 5'h02;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_04_PTR = 5'h03;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_05_PTR = 5'h04;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_06_PTR = 5'h05;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_07_PTR = 5'h06;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_08_PTR = 5'h07;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_09_PTR = 5'h08;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_10_PTR = 5'h09;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_11_PTR = 5'h0A;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_12_PTR = 5'h0B;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_13_PTR = 5'h0C;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_14_PTR = 5'h0D;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_15_PTR = 5'h0E;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_16_PTR = 5'h0F;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_17_PTR = 5'h10;
  localparam logic [PTR_W-1:0] GAMMA_LEVEL_18_PTR = 5'h11;
  localparam logic [PTR_W-1:0] COMMON_LEVEL_1_PTR = 5'h12;
  localparam logic [PTR_W-1:0] COMMON_LEVEL_2_PTR = 5'h13;
  localparam logic [PTR_W-1:0] PTR_END = 5'h14;

  // two-wire addressing and commands
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h3A;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int XFER_BIT = 7;

  // reset values
  localparam logic [CODE_W-1:0] MID_CODE = 10'h200;
  localparam logic [3:0] LINE_RST = 4'h3;

  // serial engine states and byte roles
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} dcr_state_t;
  typedef enum logic [2:0] {R_ADDR, R_PTR, R_HI, R_LO, R_GC, R_RD} dcr_role_t;

  typedef logic [NUM_REGS-1:0][CODE_W-1:0] dcr_codes_t;

  // whole state of the port; line bits: 0 clock, 1 data, 2 latch, 3 address select
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] lvl;
    dcr_state_t st;
    dcr_role_t role;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic tx_lo;
    logic [PTR_W-1:0] ptr;
    logic [1:0] hi;
    logic xfer;
    dcr_codes_t store;
    dcr_codes_t applied;
  } dcr_regs_t;

endpackage

// [core/dcr_port.sv]
/*
  Two-wire slave that loads and reads back twenty double-buffered 10-bit
  converter codes (eighteen gamma levels, two common levels).
  Assumes the bus pins and the latch and address-select pins arrive
  asynchronously; the pad combines sda_oe into an open-drain driver.
*/
module dcr_port
  import dcr_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic resetn,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // control pins
  input wire logic slave_addr_select_pin,
  input wire logic output_latch_pin,
  // converter codes
  output dcr_pkg::dcr_codes_t applied_code,
  output dcr_pkg::dcr_codes_t stored_code
);

  dcr_regs_t r_reg;
  dcr_regs_t r_next;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_end;
  logic commit;
  logic gc_hit;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // next byte to send for a read; unmapped pointers read as zero
  function automatic logic [7:0] rd_byte(input dcr_codes_t codes,
                                         input logic [PTR_W-1:0] p, input logic lo);
    logic [7:0] b;
    b = 8'h00;
    if (p < PTR_END) begin
      if (lo) begin
        b = codes[p][7:0];
      end else begin
        b = {6'h00, codes[p][CODE_W-1:8]};
      end
    end
    return b;
  endfunction

  // pointer step, parked one past the last register
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] q;
    q = p;
    if (p < PTR_END) begin
      q = p + 5'h01;
    end
    return q;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // whole port behaviour: filtering, framing, byte roles, register update
  always_comb begin
    r_next = r_reg;
    commit = 1'b0;
    gc_hit = 1'b0;
    // three-stage synchroniser; level changes when stages two and three agree
    r_next.s1 = {slave_addr_select_pin, output_latch_pin, sda_in, scl_in};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.lvl = (r_reg.lvl & (r_reg.s2 ^ r_reg.s3)) | (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3));
    scl_rise = ~r_reg.lvl[0] & r_next.lvl[0];
    scl_fall = r_reg.lvl[0] & ~r_next.lvl[0];
    // data moving while clock high frames a transfer
    start_ev = r_reg.lvl[0] & r_next.lvl[0] & r_reg.lvl[1] & ~r_next.lvl[1];
    stop_ev = r_reg.lvl[0] & r_next.lvl[0] & ~r_reg.lvl[1] & r_next.lvl[1];
    byte_end = (r_reg.st == S_RX) & scl_fall & (r_reg.cnt == BYTE_BITS);
    if (start_ev) begin
      // any pending high byte is dropped here
      r_next.st = S_RX;
      r_next.role = R_ADDR;
      r_next.cnt = 4'h0;
    end else if (stop_ev) begin
      r_next.st = S_IDLE; // release line on stop
    end else begin
      case (r_reg.st)
        S_RX: begin
          if (scl_rise) begin
            r_next.sh = {r_reg.sh[6:0], r_next.lvl[1]};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (byte_end) begin
            r_next.cnt = 4'h0;
            r_next.st = S_ACK;
            case (r_reg.role)
              R_ADDR: begin
                if (r_reg.sh[7:1] == {SLAVE_ADDR_HI, r_reg.lvl[3]}) begin
                  r_next.role = r_reg.sh[0] ? R_RD : R_PTR;
                end else if (r_reg.sh == GC_ADDR) begin
                  r_next.role = R_GC;
                end else begin
                  r_next.st = S_IDLE;
                end
              end
              R_PTR: begin
                if (r_reg.sh[7:5] == 3'h0 && r_reg.sh[4:0] < PTR_END) begin
                  r_next.ptr = r_reg.sh[4:0];
                  r_next.role = R_HI;
                end else begin
                  r_next.st = S_IDLE;
                end
              end
              R_HI: begin
                if (r_reg.ptr < PTR_END) begin
                  r_next.hi = r_reg.sh[1:0];
                  r_next.xfer = r_reg.sh[XFER_BIT];
                  r_next.role = R_LO;
                end else begin
                  r_next.st = S_IDLE;
                end
              end
              R_LO: begin
                commit = 1'b1;
                r_next.ptr = ptr_step(r_reg.ptr);
                r_next.role = R_HI;
              end
              R_GC: begin
                if (r_reg.sh == GC_RESET_CMD) begin
                  gc_hit = 1'b1;
                end else begin
                  r_next.st = S_IDLE;
                end
              end
              default: begin
                r_next.st = S_IDLE;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (r_reg.role == R_RD) begin
              // read begins at the pointed register, high byte first
              r_next.tx = rd_byte(r_reg.applied, r_reg.ptr, 1'b0);
              r_next.tx_lo = 1'b0;
              r_next.st = S_TX;
            end else begin
              r_next.st = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.cnt == BYTE_BITS) begin
              r_next.cnt = 4'h0;
              r_next.st = S_RACK;
            end else begin
              r_next.tx = {r_reg.tx[6:0], 1'b0};
            end
          end
        end
        S_RACK: begin
          if (scl_rise && r_next.lvl[1]) begin
            r_next.st = S_IDLE; // no acknowledge ends the read
          end else if (scl_fall) begin
            r_next.st = S_TX;
            if (r_reg.tx_lo) begin
              // move on to the next register
              r_next.ptr = ptr_step(r_reg.ptr);
              r_next.tx = rd_byte(r_reg.applied, ptr_step(r_reg.ptr), 1'b0);
              r_next.tx_lo = 1'b0;
            end else begin
              r_next.tx = rd_byte(r_reg.applied, r_reg.ptr, 1'b1);
              r_next.tx_lo = 1'b1;
            end
          end
        end
        default: begin
          r_next.st = S_IDLE;
        end
      endcase
    end
    // storage and output latch
    if (gc_hit) begin
      r_next.store = {NUM_REGS{MID_CODE}}; // full reset regardless of latch
      r_next.applied = {NUM_REGS{MID_CODE}};
      r_next.ptr = GAMMA_LEVEL_01_PTR;
    end else begin
      if (commit) begin
        r_next.store[r_reg.ptr] = {r_reg.hi, r_reg.sh};
      end
      if (~r_next.lvl[2] || (commit && r_reg.xfer)) begin
        r_next.applied = r_next.store;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset: bus lines idle high, every code at mid scale
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.s1 <= LINE_RST;
      r_reg.s2 <= LINE_RST;
      r_reg.s3 <= LINE_RST;
      r_reg.lvl <= LINE_RST;
      r_reg.st <= S_IDLE;
      r_reg.role <= R_ADDR;
      r_reg.store <= {NUM_REGS{MID_CODE}};
      r_reg.applied <= {NUM_REGS{MID_CODE}};
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs; data line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = (r_reg.st == S_ACK) | ((r_reg.st == S_TX) & ~r_reg.tx[7]);
  assign applied_code = r_reg.applied;
  assign stored_code = r_reg.store;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcr_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence addr_match_s;
    byte_end && !start_ev && !stop_ev && r_reg.role == R_ADDR
      && r_reg.sh[7:1] == {SLAVE_ADDR_HI, r_reg.lvl[3]};
  endsequence

  sequence read_launch_s;
    r_reg.st == S_ACK && r_reg.role == R_RD && scl_fall && !start_ev && !stop_ev;
  endsequence

  // a complete pointer byte that names a mapped register
  sequence ptr_valid_s;
    byte_end && !start_ev && !stop_ev && r_reg.role == R_PTR
      && r_reg.sh[7:5] == 3'h0 && r_reg.sh[4:0] < PTR_END;
  endsequence

  ptr_range_a: assert property (r_reg.ptr <= PTR_END)
    else $error("pointer beyond park value");

  addr_ack_a: assert property (addr_match_s |=> sda_oe && r_reg.st == S_ACK)
    else $error("own address not acknowledged");

  store_cause_a: assert property (r_reg.store != $past(r_reg.store) |-> $past(commit || gc_hit))
    else $error("store changed without a complete word");

  abort_keep_a: assert property ((start_ev || stop_ev) |=> r_reg.store == $past(r_reg.store))
    else $error("store changed on aborted word");

  ptr_step_a: assert property (commit |=> r_reg.ptr == $past(r_reg.ptr) + 5'h01)
    else $error("pointer did not advance after word");

  latch_follow_a: assert property (!r_next.lvl[2] |=> r_reg.applied == r_reg.store)
    else $error("outputs not following stores with latch low");

  latch_hold_a: assert property (r_next.lvl[2] && !gc_hit && !(commit && r_reg.xfer)
                                 |=> r_reg.applied == $past(r_reg.applied))
    else $error("outputs moved while latch held");

  soft_xfer_a: assert property (commit && r_reg.xfer |=> r_reg.applied == r_reg.store)
    else $error("bit 15 transfer missing");

  gc_reset_a: assert property (gc_hit |=> sda_oe && r_reg.applied == {NUM_REGS{MID_CODE}}
                               && r_reg.store == {NUM_REGS{MID_CODE}})
    else $error("general call reset not applied");

  read_first_a: assert property (read_launch_s |=> r_reg.st == S_TX
                                 && r_reg.tx == rd_byte(r_reg.applied, r_reg.ptr, 1'b0))
    else $error("read did not start with applied high byte");

  nack_end_a: assert property (r_reg.st == S_RACK && scl_rise && r_next.lvl[1] && !stop_ev
                               && !start_ev |=> r_reg.st == S_IDLE ##1 !sda_oe)
    else $error("read not ended on missing acknowledge");

  past_end_a: assert property (byte_end && r_reg.role == R_HI && r_reg.ptr == PTR_END
                               && !start_ev && !stop_ev |=> !sda_oe && r_reg.st == S_IDLE)
    else $error("data past last register acknowledged");

  ptr_take_a: assert property (ptr_valid_s |=> sda_oe
                               && r_reg.ptr == $past(r_reg.sh[4:0]))
    else $error("valid pointer not taken");

  ptr_refuse_a: assert property (byte_end && !start_ev && !stop_ev && r_reg.role == R_PTR
                                 && (r_reg.sh[7:5] != 3'h0 || r_reg.sh[4:0] >= PTR_END)
                                 |=> !sda_oe && r_reg.st == S_IDLE)
    else $error("invalid pointer acknowledged");

  hi_hold_a: assert property (byte_end && r_reg.role == R_HI
                              |=> r_reg.store == $past(r_reg.store))
    else $error("store changed on high byte alone");

  word_land_a: assert property (byte_end && !start_ev && !stop_ev && r_reg.role == R_LO
                                |=> r_reg.store[$past(r_reg.ptr)]
                                    == {$past(r_reg.hi), $past(r_reg.sh)})
    else $error("word not stored as two code bits and low byte");

  data_ack_a: assert property (byte_end && !start_ev && !stop_ev
                               && (r_reg.role == R_LO
                                   || (r_reg.role == R_HI && r_reg.ptr < PTR_END))
                               |=> sda_oe)
    else $error("data byte for a valid register not acknowledged");

  gc_refuse_a: assert property (byte_end && !start_ev && !stop_ev && r_reg.role == R_GC
                                && r_reg.sh != GC_RESET_CMD |=> !sda_oe)
    else $error("general call data other than reset acknowledged");

  frame_free_a: assert property (start_ev || stop_ev |=> !sda_oe)
    else $error("data line held after start or stop");

  addr_refuse_a: assert property (byte_end && !start_ev && !stop_ev
                                  && r_reg.role == R_ADDR
                                  && r_reg.sh[7:1] != {SLAVE_ADDR_HI, r_reg.lvl[3]}
                                  && r_reg.sh != GC_ADDR |=> !sda_oe)
    else $error("foreign address acknowledged");

  read_hi_form_a: assert property (read_launch_s |=> r_reg.tx[7:2] == 6'h00)
    else $error("read high byte carries more than two code bits");

endmodule

// [test/dcr_bus_master.sv]
/*
  Two-wire bus master model driving the port's clock and data pins.
  Assumes the slave pulls data low through sda_oe and a pull-up on the wire.
*/
module dcr_bus_master (
  // system
  input wire logic clk_sys,
  // two-wire bus
  output logic scl,
  output logic sda_wire,
  input wire logic sda_out,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import dcr_pkg::*;
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // open-drain wire: pull-up unless someone pulls low; slave shows its output value
  assign sda_wire = (sda_oe === 1'b1) ? (sda_out & sda_drv) : sda_drv;
  //////////////////////////////////////////////////////////////////////////
  // bus phases, changed only just after a clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic start();
    hold(6);
    sda_drv <= 1'b1;
    hold(6);
    scl <= 1'b1;
    hold(8);
    sda_drv <= 1'b0;
    hold(8);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold(6);
    sda_drv <= 1'b0;
    hold(6);
    scl <= 1'b1;
    hold(8);
    sda_drv <= 1'b1;
    hold(8);
  endtask
  // one bit slot: data set in the low phase, wire sampled mid-high
  task automatic bit_slot(input logic b, output logic seen);
    hold(6);
    sda_drv <= b;
    hold(6);
    scl <= 1'b1;
    hold(5);
    seen = sda_wire;
    hold(5);
    scl <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // bytes and words
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], s);
    end
    bit_slot(1'b1, s);
    ack = (s === 1'b0);
  endtask
  task automatic byte_in(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, d[i]);
    end
    bit_slot(~ack, s);
  endtask
  task automatic addr_out(input logic rd, input logic sel, output logic ack);
    byte_out({SLAVE_ADDR_HI, sel, rd}, ack);
  endtask
  // high byte never carries 01 in its top bits
  task automatic word_out(input logic xfer, input logic [9:0] code, output logic ack);
    logic a;
    logic b;
    byte_out({xfer, 1'b0, 4'h0, code[9:8]}, a);
    byte_out(code[7:0], b);
    ack = a & b;
  endtask
endmodule

// [test/testbench.sv]
/*
  Self-checking bench for the code register port: table of single writes
  with read-back, then reset, refusals, bursts, latch and general call.
  Assumes dcr_bus_master as the bus partner.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dcr_pkg::*;
  typedef struct packed {logic [7:0] ptr; logic [9:0] code;} dcr_row_t;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sel_pin = 1'b0;
  logic latch_pin = 1'b0;
  logic scl;
  logic sda;
  logic sda_oe;
  logic sda_out;
  logic a;
  logic [9:0] q[$];
  dcr_codes_t applied_code;
  dcr_codes_t stored_code;
  int errors = 0;
  int checks = 0;
  dcr_row_t rows [5] = '{'{8'h00, 10'h3FF}, '{8'h13, 10'h155}, '{8'h09, 10'h000},
                         '{8'h12, 10'h2AA}, '{8'h0A, 10'h001}};
  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;
  dcr_bus_master u_mst (.clk_sys(clk_sys), .scl(scl), .sda_wire(sda), .sda_out(sda_out),
    .sda_oe(sda_oe));
  dcr_port u_dut (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_select_pin(sel_pin),
    .output_latch_pin(latch_pin), .applied_code(applied_code), .stored_code(stored_code));
  //////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic all_mid();
    for (int i = 0; i < NUM_REGS; i++) begin
      check(applied_code[i], MID_CODE);
      check(stored_code[i], MID_CODE);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // transactions
  task automatic open_wr(input logic [7:0] ptr, input logic ptr_ack);
    u_mst.start();
    u_mst.addr_out(1'b0, sel_pin, a);
    check(a, 1);
    u_mst.byte_out(ptr, a);
    check(a, ptr_ack);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic xfer, input logic [9:0] code);
    open_wr(ptr, 1'b1);
    u_mst.word_out(xfer, code, a);
    check(a, 1);
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic [7:0] h;
    logic [7:0] l;
    open_wr(ptr, 1'b1);
    u_mst.start();
    u_mst.addr_out(1'b1, sel_pin, a);
    check(a, 1);
    q = {};
    for (int i = 0; i < n; i++) begin
      u_mst.byte_in(1'b1, h);
      u_mst.byte_in(i < n - 1, l);
      check(h[7:2], 0);
      q.push_back({h[1:0], l});
    end
    u_mst.stop();
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    u_mst.hold(3);
    resetn <= 1'b1;
    u_mst.hold(4);
    foreach (rows[i]) begin
      wr(rows[i].ptr, 1'b0, rows[i].code);
      check(stored_code[rows[i].ptr[4:0]], rows[i].code);
      check(applied_code[rows[i].ptr[4:0]], rows[i].code);
      rd(rows[i].ptr, 1);
      check(q[0], rows[i].code);
    end
    $display("table done");
    resetn <= 1'b0;
    u_mst.hold(3);
    resetn <= 1'b1;
    u_mst.hold(4);
    all_mid();
    $display("reset done");
    open_wr(8'h14, 1'b0);
    u_mst.stop();
    open_wr(8'h21, 1'b0);
    u_mst.stop();
    sel_pin <= 1'b1;
    u_mst.start();
    u_mst.addr_out(1'b0, 1'b0, a);
    check(a, 0);
    u_mst.stop();
    wr(8'h05, 1'b0, 10'h123);
    check(stored_code[5], 10'h123);
    sel_pin <= 1'b0;
    $display("refusal done");
    open_wr(8'h02, 1'b1);
    u_mst.word_out(1'b0, 10'h111, a);
    check(a, 1);
    u_mst.word_out(1'b0, 10'h222, a);
    check(a, 1);
    u_mst.byte_out(8'h03, a);
    check(a, 1);
    check(stored_code[4], MID_CODE);
    u_mst.start();
    u_mst.stop();
    check(stored_code[2], 10'h111);
    check(stored_code[3], 10'h222);
    check(stored_code[4], MID_CODE);
    $display("burst done");
    latch_pin <= 1'b1;
    wr(8'h02, 1'b0, 10'h0F0);
    wr(8'h04, 1'b0, 10'h3C3);
    check(stored_code[2], 10'h0F0);
    check(applied_code[2], 10'h111);
    rd(8'h02, 1);
    check(q[0], 10'h111);
    wr(8'h03, 1'b1, 10'h1E1);
    check(applied_code[2], 10'h0F0);
    check(applied_code[3], 10'h1E1);
    wr(8'h04, 1'b0, 10'h2D2);
    check(applied_code[4], 10'h3C3);
    latch_pin <= 1'b0;
    u_mst.hold(8);
    check(applied_code[4], 10'h2D2);
    $display("latch done");
    rd(8'h02, 3);
    check(q[0], 10'h0F0);
    check(q[1], 10'h1E1);
    check(q[2], 10'h2D2);
    check(sda_oe, 0);
    open_wr(8'h13, 1'b1);
    u_mst.word_out(1'b0, 10'h0AB, a);
    check(a, 1);
    u_mst.byte_out(8'h01, a);
    check(a, 0);
    u_mst.stop();
    check(stored_code[19], 10'h0AB);
    check(stored_code[0], MID_CODE);
    $display("read and end done");
    u_mst.start();
    u_mst.byte_out(GC_ADDR, a);
    check(a, 1);
    u_mst.byte_out(8'h05, a);
    check(a, 0);
    u_mst.stop();
    check(stored_code[2], 10'h0F0);
    latch_pin <= 1'b1;
    u_mst.start();
    u_mst.byte_out(GC_ADDR, a);
    u_mst.byte_out(GC_RESET_CMD, a);
    check(a, 1);
    u_mst.stop();
    all_mid();
    $display("general call done");
    finish_test();
  end
endmodule
